// file: src/icc_consts.svh
`ifndef ICC_CONSTS_SVH
`define ICC_CONSTS_SVH

// Capture mode codes
`define ICC_MODE_OFF      3'h0
`define ICC_MODE_EDGE     3'h1
`define ICC_MODE_FALL     3'h2
`define ICC_MODE_RISE     3'h3
`define ICC_MODE_RISE4    3'h4
`define ICC_MODE_RISE16   3'h5
`define ICC_MODE_UNUSED   3'h6
`define ICC_MODE_IRQONLY  3'h7

// Prescaler terminal counts (edges minus one) and reset value
`define ICC_PRE4_LAST     4'h3
`define ICC_PRE16_LAST    4'hF
`define ICC_PRE_RESET     4'h0

// Buffer geometry and reset values
`define ICC_WORD_W        16
`define ICC_FIFO_DEPTH    3'h4
`define ICC_CNT_RESET     3'h0
`define ICC_WORD_RESET    16'h0000
`define ICC_IRQCNT_RESET  2'h0

// Timebase select values
`define ICC_TB_TIMER2     1'b1
`define ICC_TB_TIMER3     1'b0

`endif

// file: src/icc_pkg.sv
`include "icc_consts.svh"

package icc_pkg;
  typedef logic [`ICC_WORD_W-1:0] icc_word_t;
  typedef logic [2:0]             icc_mode_t;
  typedef logic [2:0]             icc_cnt_t;
  typedef logic [3:0]             icc_pre_t;
  typedef logic [1:0]             icc_irqcnt_t;
endpackage

// file: src/icc_fifo.sv
`timescale 1ns/10ps
`include "icc_consts.svh"

module icc_fifo (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_push,
  input  wire icc_pkg::icc_word_t i_push_data,
  input  wire logic              i_pop,
  output icc_pkg::icc_word_t     o_head,
  output icc_pkg::icc_cnt_t      o_count,
  output logic                   o_not_empty
);

  icc_pkg::icc_word_t mem_r   [4];
  icc_pkg::icc_word_t mem_nxt [4];
  icc_pkg::icc_cnt_t  cnt_r;
  icc_pkg::icc_cnt_t  cnt_nxt;
  logic               ne_r;
  logic               ne_nxt;

  always_comb begin
    icc_pkg::icc_cnt_t mid;
    mid = cnt_r;
    for (int i = 0; i < 4; i++) begin
      mem_nxt[i] = mem_r[i];
    end
    // Oldest word leaves, rest advance one slot
    if (i_pop && (cnt_r != `ICC_CNT_RESET)) begin
      for (int i = 0; i < 3; i++) begin
        mem_nxt[i] = mem_r[i+1];
      end
      mid = cnt_r - 3'h1;
    end
    cnt_nxt = mid;
    // Tail write only while room remains
    if (i_push && (mid != `ICC_FIFO_DEPTH)) begin
      mem_nxt[mid[1:0]] = i_push_data;
      cnt_nxt = mid + 3'h1;
    end
    ne_nxt = (cnt_nxt != `ICC_CNT_RESET);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < 4; i++) begin
        mem_r[i] <= `ICC_WORD_RESET;
      end
      cnt_r <= `ICC_CNT_RESET;
      ne_r  <= 1'b0;
    end else begin
      mem_r <= mem_nxt;
      cnt_r <= cnt_nxt;
      ne_r  <= ne_nxt;
    end
  end

  assign o_head      = mem_r[0];
  assign o_count     = cnt_r;
  assign o_not_empty = ne_r;

endmodule

// file: src/icc_top.sv
`timescale 1ns/10ps
`include "icc_consts.svh"

module icc_top (
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  input  wire logic               i_capture_input_one,
  input  wire icc_pkg::icc_word_t i_timer2_count,
  input  wire icc_pkg::icc_word_t i_timer3_count,
  input  wire icc_pkg::icc_mode_t i_capture_mode_select,
  input  wire logic               i_timebase_select,
  input  wire logic [1:0]         i_events_per_interrupt,
  input  wire logic               i_stop_in_idle,
  input  wire logic               i_cpu_idle,
  input  wire logic               i_cpu_sleep,
  input  wire logic               i_capture_irq_enable,
  input  wire logic               i_capture_irq_flag_clr,
  input  wire logic               i_fifo_read,
  output icc_pkg::icc_word_t      o_fifo_data,
  output logic                    o_fifo_not_empty_flag,
  output logic                    o_capture_overflow_flag,
  output logic                    o_capture_irq_flag,
  output logic                    o_wake
);

  // Pin synchroniser and edge history
  logic sync1_r;
  logic sync2_r;
  logic prev_r;
  logic sync1_nxt;
  logic sync2_nxt;
  logic prev_nxt;

  // Channel state
  icc_pkg::icc_pre_t    pre_r;
  icc_pkg::icc_pre_t    pre_nxt;
  icc_pkg::icc_irqcnt_t irqcnt_r;
  icc_pkg::icc_irqcnt_t irqcnt_nxt;
  logic                 ovf_r;
  logic                 ovf_nxt;
  logic                 irq_r;
  logic                 irq_nxt;
  logic                 wake_r;
  logic                 wake_nxt;
  icc_pkg::icc_word_t   data_r;
  icc_pkg::icc_word_t   data_nxt;

  // Combinational terms
  logic               rise;
  logic               fall;
  logic               active;
  logic               event_hit;
  logic               store;
  logic               lost;
  logic               accepted;
  logic               push;
  logic               pop;
  logic               irq_set;
  logic               every_irq;
  icc_pkg::icc_word_t tb_count;
  icc_pkg::icc_word_t head;
  icc_pkg::icc_cnt_t  count;
  logic               not_empty;

  always_comb begin
    // Second stage alone reads the first
    sync1_nxt = i_capture_input_one;
    sync2_nxt = sync1_r;
    prev_nxt  = sync2_r;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r  <= prev_nxt;
    end
  end

  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;

  // Timebase choice; low is the default third timer
  assign tb_count = (i_timebase_select == `ICC_TB_TIMER2) ? i_timer2_count : i_timer3_count;

  always_comb begin
    // Stop-in-idle blocks events but the prescaler still counts; unused code captures nothing but, unlike off, keeps the prescaler
    active = (i_capture_mode_select != `ICC_MODE_OFF)
          && (i_capture_mode_select != `ICC_MODE_UNUSED)
          && !(i_cpu_idle && i_stop_in_idle);
    pre_nxt   = pre_r;
    event_hit = 1'b0;
    unique case (i_capture_mode_select)
      `ICC_MODE_EDGE:    event_hit = rise | fall;
      `ICC_MODE_FALL:    event_hit = fall;
      `ICC_MODE_RISE:    event_hit = rise;
      `ICC_MODE_IRQONLY: event_hit = rise;
      `ICC_MODE_RISE4: begin
        if (rise) begin
          event_hit = (pre_r >= `ICC_PRE4_LAST);
          pre_nxt   = event_hit ? `ICC_PRE_RESET : pre_r + 4'h1;
        end
      end
      `ICC_MODE_RISE16: begin
        if (rise) begin
          event_hit = (pre_r == `ICC_PRE16_LAST);
          pre_nxt   = event_hit ? `ICC_PRE_RESET : pre_r + 4'h1;
        end
      end
      `ICC_MODE_OFF, `ICC_MODE_UNUSED: event_hit = 1'b0;
    endcase
    // Sleep leaves only the interrupt-only mode working
    if (!active || (i_cpu_sleep && (i_capture_mode_select != `ICC_MODE_IRQONLY))) begin
      event_hit = 1'b0;
    end
    if (i_capture_mode_select == `ICC_MODE_OFF) begin
      pre_nxt = `ICC_PRE_RESET;
    end
  end

  always_comb begin
    // Interrupt-only mode stores nothing while asleep or idle
    store = event_hit && !((i_capture_mode_select == `ICC_MODE_IRQONLY)
                           && (i_cpu_sleep || i_cpu_idle));
    // Full buffer or pending overflow drops the event
    // A pending overflow blocks every mode, every-edge mode included
    lost  = store && (ovf_r || ((count == `ICC_FIFO_DEPTH)
                  && (i_capture_mode_select != `ICC_MODE_EDGE)));
    push  = store && !lost && (count != `ICC_FIFO_DEPTH);
    pop   = i_fifo_read && not_empty;
    accepted = event_hit && !lost;
    // Overflow only on the fifth event, never in every-edge mode
    ovf_nxt = ovf_r;
    if (ovf_r && pop && (count == 3'h1)) begin
      ovf_nxt = 1'b0;
    end
    if (store && !ovf_r && (count == `ICC_FIFO_DEPTH)
        && (i_capture_mode_select != `ICC_MODE_EDGE)) begin
      ovf_nxt = 1'b1;
    end
  end

  always_comb begin
    every_irq  = (i_capture_mode_select == `ICC_MODE_EDGE) || i_cpu_sleep;
    irqcnt_nxt = irqcnt_r;
    irq_set    = 1'b0;
    if (accepted) begin
      if (every_irq || (irqcnt_r == i_events_per_interrupt)) begin
        irq_set    = 1'b1;
        irqcnt_nxt = `ICC_IRQCNT_RESET;
      end else begin
        irqcnt_nxt = irqcnt_r + 2'h1;
      end
    end
    if (i_capture_mode_select == `ICC_MODE_OFF) begin
      irqcnt_nxt = `ICC_IRQCNT_RESET;
    end
    // A new event beats a clear in the same cycle
    irq_nxt  = (irq_r && !i_capture_irq_flag_clr) || irq_set;
    wake_nxt = event_hit && (i_capture_mode_select == `ICC_MODE_IRQONLY)
            && i_capture_irq_enable && (i_cpu_sleep || i_cpu_idle);
    // Empty read returns the stale head word
    data_nxt = i_fifo_read ? head : data_r;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pre_r    <= `ICC_PRE_RESET;
      irqcnt_r <= `ICC_IRQCNT_RESET;
      ovf_r    <= 1'b0;
      irq_r    <= 1'b0;
      wake_r   <= 1'b0;
      data_r   <= `ICC_WORD_RESET;
    end else begin
      pre_r    <= pre_nxt;
      irqcnt_r <= irqcnt_nxt;
      ovf_r    <= ovf_nxt;
      irq_r    <= irq_nxt;
      wake_r   <= wake_nxt;
      data_r   <= data_nxt;
    end
  end

  icc_fifo u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_push      (push),
    .i_push_data (tb_count),
    .i_pop       (pop),
    .o_head      (head),
    .o_count     (count),
    .o_not_empty (not_empty)
  );

  assign o_fifo_data             = data_r;
  assign o_fifo_not_empty_flag   = not_empty;
  assign o_capture_overflow_flag = ovf_r;
  assign o_capture_irq_flag      = irq_r;
  assign o_wake                  = wake_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_full_fifth;
    (count == `ICC_FIFO_DEPTH) && store && !pop
      && (i_capture_mode_select != `ICC_MODE_EDGE);
  endsequence

  sequence s_read_word;
    i_fifo_read && not_empty;
  endsequence

  property p_not_empty_on_capture;
    push |=> o_fifo_not_empty_flag;
  endproperty
  a_not_empty_on_capture: assert property (p_not_empty_on_capture)
    else $error("not-empty flag missing after capture");

  property p_read_oldest;
    s_read_word |=> (o_fifo_data == $past(head)) && (count != `ICC_FIFO_DEPTH);
  endproperty
  a_read_oldest: assert property (p_read_oldest)
    else $error("read did not return oldest word");

  property p_overflow_set;
    s_full_fifth |=> o_capture_overflow_flag && (count == `ICC_FIFO_DEPTH);
  endproperty
  a_overflow_set: assert property (p_overflow_set)
    else $error("overflow flag not set on fifth capture");

  property p_fifth_dropped;
    s_full_fifth |=> $stable(head);
  endproperty
  a_fifth_dropped: assert property (p_fifth_dropped)
    else $error("fifth capture altered buffer");

  property p_blocked_after_overflow;
    o_capture_overflow_flag |-> !push;
  endproperty
  a_blocked_after_overflow: assert property (p_blocked_after_overflow)
    else $error("capture stored while overflowed");

  property p_timebase_pick;
    push |-> (tb_count == (i_timebase_select ? i_timer2_count : i_timer3_count));
  endproperty
  a_timebase_pick: assert property (p_timebase_pick)
    else $error("wrong timebase captured");

  property p_edge_mode_irq;
    (accepted && (i_capture_mode_select == `ICC_MODE_EDGE)) |=> o_capture_irq_flag;
  endproperty
  a_edge_mode_irq: assert property (p_edge_mode_irq)
    else $error("every-edge event gave no interrupt flag");

  property p_edge_no_overflow;
    (i_capture_mode_select == `ICC_MODE_EDGE) |=> !$rose(o_capture_overflow_flag);
  endproperty
  a_edge_no_overflow: assert property (p_edge_no_overflow)
    else $error("overflow raised in every-edge mode");

  property p_wake;
    (event_hit && (i_capture_mode_select == `ICC_MODE_IRQONLY) && i_capture_irq_enable
      && (i_cpu_sleep || i_cpu_idle)) |=> o_wake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake on interrupt-only event");

  property p_idle_irq_only;
    ((i_capture_mode_select == `ICC_MODE_IRQONLY) && (i_cpu_idle || i_cpu_sleep)) |-> !push;
  endproperty
  a_idle_irq_only: assert property (p_idle_irq_only)
    else $error("value stored in interrupt-only low-power mode");

  property p_prescaler_clear;
    (i_capture_mode_select == `ICC_MODE_OFF) |=> (pre_r == `ICC_PRE_RESET);
  endproperty
  a_prescaler_clear: assert property (p_prescaler_clear)
    else $error("prescaler not cleared while off");

  property p_rise4_count;
    ((i_capture_mode_select == `ICC_MODE_RISE4) && event_hit) |-> (pre_r == `ICC_PRE4_LAST);
  endproperty
  a_rise4_count: assert property (p_rise4_count)
    else $error("divide-by-four event on wrong edge");

  property p_sync_single;
    rise |=> !rise;
  endproperty
  a_sync_single: assert property (p_sync_single)
    else $error("one pin edge gave two events");

endmodule

// file: tb/icc_hall_src.sv
`timescale 1ns/10ps

// Edge source standing in for a Hall sensor on the capture pin
module icc_hall_src (
  input  wire logic i_clk,
  output logic      o_pin
);
  initial begin
    o_pin = 1'b0;
  end

  // Clean level changes only; each one is held long enough to pass the synchroniser
  task automatic drive(input logic v, input int hold);
    @(posedge i_clk);
    o_pin <= v;
    repeat (hold) @(posedge i_clk);
  endtask
endmodule

// file: tb/tb_top.sv
`timescale 1ns/10ps
`include "icc_consts.svh"

module tb_top;
  logic               i_clk = 1'b0;
  logic               i_rst_n = 1'b0;
  logic               pin;
  icc_pkg::icc_word_t t2 = 16'h0000;
  icc_pkg::icc_word_t t3 = 16'h0000;
  icc_pkg::icc_mode_t mode = `ICC_MODE_OFF;
  logic               tsel = `ICC_TB_TIMER3;
  logic [1:0]         epi = 2'h0;
  logic               sidl = 1'b0;
  logic               idle = 1'b0;
  logic               sleep = 1'b0;
  logic               ien = 1'b0;
  logic               clr = 1'b0;
  logic               rd = 1'b0;
  icc_pkg::icc_word_t data;
  logic               ne;
  logic               ovf;
  logic               irq;
  logic               wake;
  logic [15:0]        stamp = 16'h0000;
  int                 wakes = 0;
  int                 fails = 0;
  int                 comparisons = 0;

  always #2 i_clk = ~i_clk;

  always @(posedge i_clk) begin
    if (wake === 1'b1) wakes <= wakes + 1;
  end

  icc_hall_src src (.i_clk(i_clk), .o_pin(pin));

  icc_top dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_capture_input_one(pin),
    .i_timer2_count(t2), .i_timer3_count(t3), .i_capture_mode_select(mode),
    .i_timebase_select(tsel), .i_events_per_interrupt(epi), .i_stop_in_idle(sidl),
    .i_cpu_idle(idle), .i_cpu_sleep(sleep), .i_capture_irq_enable(ien),
    .i_capture_irq_flag_clr(clr), .i_fifo_read(rd), .o_fifo_data(data),
    .o_fifo_not_empty_flag(ne), .o_capture_overflow_flag(ovf),
    .o_capture_irq_flag(irq), .o_wake(wake));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    chk(n, {15'h0000, e}, {15'h0000, g});
  endtask

  // Timers move before each pin change so every capture carries a distinct stamp
  task automatic edge_to(input logic v);
    @(posedge i_clk);
    stamp = stamp + 16'h0001;
    t2 <= 16'hA000 + stamp;
    t3 <= 16'h3000 + stamp;
    src.drive(v, 6);
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      edge_to(1'b1);
      edge_to(1'b0);
    end
  endtask

  task automatic rd_chk(input logic [15:0] e);
    @(posedge i_clk);
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    @(posedge i_clk);
    #1 chk("fifo_data", e, data);
  endtask

  task automatic setup(input icc_pkg::icc_mode_t m, input logic ts, input logic [1:0] ep);
    @(posedge i_clk);
    mode <= m;
    tsel <= ts;
    epi <= ep;
    clr <= 1'b1;
    @(posedge i_clk);
    clr <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask

  task automatic t_fifo;
    logic [15:0] b;
    setup(`ICC_MODE_RISE, `ICC_TB_TIMER3, 2'h0);
    b = stamp;
    pulses(4);
    chk1("not_empty", 1'b1, ne);
    chk1("overflow", 1'b0, ovf);
    pulses(1);
    chk1("overflow", 1'b1, ovf);
    pulses(1);
    for (int i = 0; i < 4; i++) begin
      rd_chk(16'h3000 + b + 16'(2 * i + 1));
      chk1("not_empty", i < 3, ne);
      if (i == 0) pulses(1);
    end
    chk1("overflow", 1'b0, ovf);
    $display("test fifo done");
  endtask

  task automatic t_fall_t2;
    logic [15:0] b;
    setup(`ICC_MODE_FALL, `ICC_TB_TIMER2, 2'h0);
    b = stamp;
    edge_to(1'b1);
    chk1("not_empty", 1'b0, ne);
    edge_to(1'b0);
    rd_chk(16'hA000 + b + 16'h0002);
    chk1("not_empty", 1'b0, ne);
    $display("test falling done");
  endtask

  task automatic t_prescale;
    logic [15:0] b;
    setup(`ICC_MODE_RISE4, `ICC_TB_TIMER3, 2'h0);
    pulses(3);
    setup(`ICC_MODE_OFF, `ICC_TB_TIMER3, 2'h0);
    setup(`ICC_MODE_RISE4, `ICC_TB_TIMER3, 2'h0);
    pulses(3);
    chk1("not_empty", 1'b0, ne);
    b = stamp;
    pulses(1);
    rd_chk(16'h3000 + b + 16'h0001);
    setup(`ICC_MODE_RISE16, `ICC_TB_TIMER3, 2'h0);
    pulses(15);
    chk1("not_empty", 1'b0, ne);
    b = stamp;
    pulses(1);
    rd_chk(16'h3000 + b + 16'h0001);
    $display("test prescale done");
  endtask

  task automatic t_every_edge;
    logic [15:0] b;
    setup(`ICC_MODE_EDGE, `ICC_TB_TIMER3, 2'h3);
    b = stamp;
    edge_to(1'b1);
    chk1("irq_flag", 1'b1, irq);
    setup(`ICC_MODE_EDGE, `ICC_TB_TIMER3, 2'h3);
    chk1("irq_flag", 1'b0, irq);
    edge_to(1'b0);
    chk1("irq_flag", 1'b1, irq);
    pulses(2);
    chk1("overflow", 1'b0, ovf);
    for (int i = 1; i < 5; i++) rd_chk(16'h3000 + b + 16'(i));
    chk1("not_empty", 1'b0, ne);
    $display("test every edge done");
  endtask

  task automatic t_irq_count;
    setup(`ICC_MODE_RISE, `ICC_TB_TIMER3, 2'h1);
    pulses(1);
    chk1("irq_flag", 1'b0, irq);
    pulses(1);
    chk1("irq_flag", 1'b1, irq);
    rd_chk(16'h3000 + stamp - 16'h0003);
    rd_chk(16'h3000 + stamp - 16'h0001);
    $display("test irq count done");
  endtask

  task automatic t_wake;
    int w;
    setup(`ICC_MODE_IRQONLY, `ICC_TB_TIMER3, 2'h3);
    ien <= 1'b1;
    sleep <= 1'b1;
    w = wakes;
    pulses(1);
    chk("wake_count", 16'(w + 1), 16'(wakes));
    chk1("irq_flag", 1'b1, irq);
    chk1("not_empty", 1'b0, ne);
    sleep <= 1'b0;
    idle <= 1'b1;
    sidl <= 1'b0;
    pulses(1);
    chk("wake_count", 16'(w + 2), 16'(wakes));
    chk1("not_empty", 1'b0, ne);
    idle <= 1'b0;
    ien <= 1'b0;
    $display("test wake done");
  endtask

  // Mid-run reset must drop a half-counted prescale
  task automatic t_reset_pre;
    logic [15:0] b;
    setup(`ICC_MODE_RISE4, `ICC_TB_TIMER3, 2'h0);
    pulses(3);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1 chk1("not_empty", 1'b0, ne);
    pulses(3);
    chk1("not_empty", 1'b0, ne);
    b = stamp;
    pulses(1);
    rd_chk(16'h3000 + b + 16'h0001);
    $display("test reset prescale done");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge i_clk);
    fails++;
    wrap_up();
  end

  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    #1 chk1("not_empty", 1'b0, ne);
    chk1("overflow", 1'b0, ovf);
    chk1("irq_flag", 1'b0, irq);
    t_fifo();
    t_fall_t2();
    t_prescale();
    t_every_edge();
    t_irq_count();
    t_wake();
    t_reset_pre();
    wrap_up();
  end
endmodule
